// ==== hdl/itc_pkg.sv ====
// constants and types for the touch converter register bank
package itc_pkg;

   localparam logic [7:0] ADDR_STATUS = 8'h00; // status
   localparam logic [7:0] ADDR_RES_LO = 8'h02; // first result byte
   localparam logic [7:0] ADDR_RES_HI = 8'h09; // last result byte
   localparam logic [7:0] ADDR_RESET = 8'h0A; // reset and config mode
   localparam logic [7:0] ADDR_EN = 8'h0C; // channel enables
   localparam logic [7:0] ADDR_SCAN = 8'h0D; // normal scan rate
   localparam logic [7:0] ADDR_CHAN0_AMPLIFICATION = 8'h0E; // channel 0 gain
   localparam int BIT_CFG = 0; // config mode bit
   localparam int BIT_FULL = 4; // full reset bit
   localparam int BIT_READY = 6; // chip ready status bit
   localparam logic [7:0] RST_EN4 = 8'h1F; // four-channel enables
   localparam logic [7:0] RST_EN2 = 8'h13; // two-channel, low nibble fixed
   localparam logic [3:0] EN2_FIXED = 4'h3; // channels 0,1 always on
   localparam logic [1:0] RST_SCAN = 2'h1; // 40 samples per second
   localparam logic [5:0] RST_GAIN = 6'h28; // gain default
   localparam int NCH = 4; // channel count
   localparam int RES_W = 12; // result width
   localparam int CLK_MHZ = 200; // sys_clk rate
   localparam int READY_NS = 80; // internal settle after full reset
   localparam int READY_CYC = (READY_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] READY_CNT = 8'(READY_CYC);

   typedef enum logic [2:0] {
      ST_BOOT = 3'h1,
      ST_RUN = 3'h2,
      ST_CFG = 3'h4
   } itc_state_type;

   // true for an address inside the result window
   function automatic logic itc_is_res(input logic [7:0] a);
      return (a >= ADDR_RES_LO) && (a <= ADDR_RES_HI);
   endfunction

   // channel index of a result address
   function automatic logic [1:0] itc_res_chan(input logic [7:0] a);
      logic [7:0] off;
      off = a - ADDR_RES_LO;
      return off[2:1];
   endfunction
endpackage

// ==== hdl/itc_res_if.sv ====
// link between register control and result store
`timescale 1ns/100ps
`default_nettype none
interface itc_res_if;
   import itc_pkg::*;
   logic upd; // accept one finished conversion
   logic [1:0] chan; // channel of that conversion
   logic [RES_W-1:0] data; // its 12-bit value
   logic lock; // status read: snapshot results
   logic clr; // full reset: clear results
   logic [RES_W-1:0] locked [NCH]; // snapshot seen by reads
   modport ctl (output upd, chan, data, lock, clr, input locked);
   modport store (input upd, chan, data, lock, clr, output locked);
endinterface
`default_nettype wire

// ==== hdl/itc_result_store.sv ====
// live and locked channel results
`timescale 1ns/100ps
`default_nettype none
module itc_result_store
(
   input wire logic sys_clk, // system clock
   input wire logic reset, // synchronous reset, high
   input wire logic ce, // clock enable
   itc_res_if.store rs // results from control
);
   import itc_pkg::*;

   logic [RES_W-1:0] live_q [NCH]; // latest conversions
   logic [RES_W-1:0] live_d [NCH];
   logic [RES_W-1:0] lock_q [NCH]; // copy frozen at status read
   logic [RES_W-1:0] lock_d [NCH];

   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         // whole words only, so a read never sees half a result
         always_comb
         begin
            live_d[g] = live_q[g];
            lock_d[g] = lock_q[g];
            if (rs.clr)
            begin
               live_d[g] = '0;
               lock_d[g] = '0;
            end
            else
            begin
               if (rs.upd && (rs.chan == 2'(g)))
                  live_d[g] = rs.data;
               if (rs.lock)
                  lock_d[g] = live_q[g];
            end
         end

         // register stage
         always_ff @(posedge sys_clk)
         begin
            if (reset)
            begin
               live_q[g] <= '0;
               lock_q[g] <= '0;
            end
            else if (ce)
            begin
               live_q[g] <= live_d[g];
               lock_q[g] <= lock_d[g];
            end
         end
         assign rs.locked[g] = lock_q[g];
      end
   endgenerate

   AST_LOCK_HOLDS: assert property (@(posedge sys_clk) disable iff (reset)
      !rs.lock && !rs.clr |=> $stable(lock_q[1]))
      else $error("locked result changed without a status read");
   AST_LIVE_WHOLE: assert property (@(posedge sys_clk) disable iff (reset)
      ce && rs.upd && !rs.clr && rs.chan == 2'h0 |=> live_q[0] == $past(rs.data))
      else $error("channel 0 result not stored whole");
endmodule // itc_result_store
`default_nettype wire

// ==== hdl/itc_regs.sv ====
// register bank of the inductive touch converter
`timescale 1ns/100ps
`default_nettype none
module itc_regs
#(
   parameter bit FOUR_CHAN = 1'b1 // four-channel variant
)
(
   input wire logic sys_clk, // system clock
   input wire logic reset, // synchronous reset, high
   input wire logic ce, // clock enable
   input wire logic reg_addr_ld, // load register pointer
   input wire logic [7:0] reg_addr, // pointer value
   input wire logic reg_wr, // write byte at pointer
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_rd, // read byte at pointer
   output logic [7:0] reg_rdata, // read data
   output logic reg_rvalid, // read data valid pulse
   input wire logic conv_valid, // conversion done pulse
   input wire logic [1:0] conv_chan, // converted channel
   input wire logic [itc_pkg::RES_W-1:0] conv_data, // result
   output logic conv_run, // conversions allowed
   output logic chip_ready, // chip ready after reset
   output logic [3:0] chan_on, // channel enables
   output logic [3:0] lowpwr_on, // low-power enables
   output logic [1:0] normal_sample_rate_sel, // scan rate
   output logic [5:0] chan0_amplification // channel 0 gain
);
   import itc_pkg::*;

   localparam logic [7:0] RST_EN = FOUR_CHAN ? RST_EN4 : RST_EN2;

   itc_res_if rs (); // link to result store

   itc_state_type state_q; // boot, run or config
   itc_state_type state_d;
   logic [7:0] cnt_q; // ready countdown
   logic [7:0] cnt_d;
   logic cfg_q; // config mode bit
   logic cfg_d;
   logic [7:0] en_q; // enable register
   logic [7:0] en_d;
   logic [1:0] scan_q; // scan rate code
   logic [1:0] scan_d;
   logic [5:0] gain_q; // gain field
   logic [5:0] gain_d;
   logic [7:0] ptr_q; // auto-increment pointer
   logic [7:0] ptr_d;
   logic [7:0] rdata_q; // read byte
   logic [7:0] rdata_d;
   logic rvalid_q; // read valid
   logic rvalid_d;
   logic run_q; // conversion gate
   logic run_d; // next conversion gate
   logic ready_q; // ready flag
   logic ready_d; // next ready flag
   logic [7:0] cur; // address this access uses
   logic full_rst; // full-reset write seen
   logic wr_ok; // write accepted

   // pointer may be loaded and used in the same cycle
   always_comb
   begin
      cur = reg_addr_ld ? reg_addr : ptr_q;
      full_rst = reg_wr && (cur == ADDR_RESET) && reg_wdata[BIT_FULL];
      // writes are refused during the settle time after a full reset
      wr_ok = reg_wr && (state_q != ST_BOOT);
   end

   // register byte seen by a read
   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      logic [RES_W-1:0] v;
      logic [7:0] r;
      v = rs.locked[itc_res_chan(a)];
      r = 8'h00;
      if (itc_is_res(a))
         r = a[0] ? {4'h0, v[11:8]} : v[7:0];
      else
      begin
         case (a)
            ADDR_STATUS: r[BIT_READY] = (state_q != ST_BOOT);
            ADDR_RESET: r[BIT_CFG] = cfg_q;
            ADDR_EN: r = FOUR_CHAN ? en_q : {en_q[7:4], 4'h0};
            ADDR_SCAN: r = {6'h00, scan_q};
            ADDR_CHAN0_AMPLIFICATION: r = {2'h0, gain_q};
            default: r = 8'h00; // unmapped reads zero
         endcase
      end
      return r;
   endfunction

   // next state of pointer and read path
   always_comb
   begin
      ptr_d = cur;
      rdata_d = rdata_q;
      rvalid_d = 1'b0;
      if (reg_rd)
      begin
         rdata_d = rd_mux(cur);
         rvalid_d = 1'b1;
      end
      if (reg_rd || reg_wr)
         ptr_d = 8'(cur + 8'h01);
   end

   // next state of control registers and mode
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      cfg_d = cfg_q;
      en_d = en_q;
      scan_d = scan_q;
      gain_d = gain_q;
      if (full_rst)
      begin
         cfg_d = 1'b0;
         en_d = RST_EN;
         scan_d = RST_SCAN;
         gain_d = RST_GAIN;
         state_d = ST_BOOT;
         cnt_d = READY_CNT;
      end
      else
      begin
         if (wr_ok)
         begin
            case (cur)
               ADDR_RESET: cfg_d = reg_wdata[BIT_CFG];
               ADDR_EN: en_d = FOUR_CHAN ? reg_wdata : {reg_wdata[7:4], EN2_FIXED};
               ADDR_SCAN: scan_d = reg_wdata[1:0];
               ADDR_CHAN0_AMPLIFICATION: gain_d = reg_wdata[5:0];
               default: cfg_d = cfg_q; // read-only or unmapped
            endcase
         end
         case (state_q)
            ST_BOOT:
            begin
               if (cnt_q <= 8'h01)
                  state_d = cfg_q ? ST_CFG : ST_RUN;
               else
                  cnt_d = 8'(cnt_q - 8'h01);
            end
            ST_RUN: if (cfg_d) state_d = ST_CFG;
            ST_CFG: if (!cfg_d) state_d = ST_RUN;
            default: state_d = ST_BOOT; // lost one-hot code
         endcase
      end
      // gate and flag follow the next state so they change with it
      run_d = (state_d == ST_RUN);
      ready_d = (state_d != ST_BOOT);
   end

   // register all control state
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_q <= ST_RUN;
         cnt_q <= 8'h00;
         cfg_q <= 1'b0;
         en_q <= RST_EN;
         scan_q <= RST_SCAN;
         gain_q <= RST_GAIN;
         ptr_q <= 8'h00;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
         run_q <= 1'b1;
         ready_q <= 1'b1;
      end
      else if (ce)
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cfg_q <= cfg_d;
         en_q <= en_d;
         scan_q <= scan_d;
         gain_q <= gain_d;
         ptr_q <= ptr_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         run_q <= run_d;
         ready_q <= ready_d;
      end
   end

   // conversions land only while running on an enabled channel
   always_comb
   begin
      rs.upd = ce && conv_valid && run_q && en_q[conv_chan];
      rs.chan = conv_chan;
      rs.data = conv_data;
      // locking on status read keeps bytes of a word coherent
      rs.lock = ce && reg_rd && (cur == ADDR_STATUS);
      rs.clr = ce && full_rst;
   end

   itc_result_store u_store (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .rs(rs.store)
   );

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign conv_run = run_q;
   assign chip_ready = ready_q;
   assign chan_on = en_q[3:0];
   assign lowpwr_on = en_q[7:4];
   assign normal_sample_rate_sel = scan_q;
   assign chan0_amplification = gain_q;

   AST_BURST_INC: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && !reg_addr_ld |=> ptr_q == 8'($past(ptr_q) + 8'h01))
      else $error("pointer did not advance after a read");
   AST_FULL_DEFAULTS: assert property (@(posedge sys_clk) disable iff (reset)
      ce && full_rst |=> en_q == RST_EN && scan_q == RST_SCAN && gain_q == RST_GAIN && !cfg_q)
      else $error("full reset left a register off its default");
   AST_NOT_READY: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      full_rst |=> (!ready_q && !run_q) [*8])
      else $error("operation resumed before ready");
   AST_READY_BACK: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      full_rst ##1 (!full_rst) [*8] ##1 (!full_rst) [*8] |-> ##[1:8] ready_q)
      else $error("chip ready never returned");
   AST_CFG_NO_CONV: assert property (@(posedge sys_clk) disable iff (reset)
      cfg_q && state_q == ST_CFG |-> !run_q && !rs.upd)
      else $error("conversion accepted in config mode");
   AST_CFG_KEEP: assert property (@(posedge sys_clk) disable iff (reset)
      !reg_wr |=> $stable(en_q) && $stable(scan_q) && $stable(gain_q))
      else $error("setting changed without a write");
   AST_TWO_CH_FIXED: assert property (@(posedge sys_clk) disable iff (reset)
      !FOUR_CHAN |-> chan_on == EN2_FIXED)
      else $error("two-channel enables not fixed");
   AST_CH1_LOW: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == 8'h04 |=> reg_rdata == rs.locked[1][7:0] && reg_rvalid)
      else $error("channel 1 low byte wrong");
   AST_HIGH_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && itc_is_res(cur) && cur[0] |=> reg_rdata[7:4] == 4'h0)
      else $error("result high byte upper bits not zero");
   AST_SCAN_RST: assert property (@(posedge sys_clk)
      reset |=> normal_sample_rate_sel == RST_SCAN)
      else $error("scan rate reset code wrong");

   // result bytes come from the locked copy, low byte on the even address
   AST_CH0_LOW: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == ADDR_RES_LO |=> reg_rdata == rs.locked[0][7:0])
      else $error("channel 0 low byte wrong");
   AST_CH0_HIGH: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == ADDR_RES_LO + 8'h01 |=> reg_rdata == {4'h0, rs.locked[0][11:8]})
      else $error("channel 0 high byte wrong");
   AST_CH2_LOW: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == ADDR_RES_LO + 8'h04 |=> reg_rdata == rs.locked[2][7:0])
      else $error("channel 2 low byte wrong");
   AST_CH3_HIGH: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == ADDR_RES_HI |=> reg_rdata == {4'h0, rs.locked[3][11:8]})
      else $error("channel 3 high byte wrong");

   // reads show the stored fields with reserved bits, and the fixed two-channel enables, at zero
   AST_STATUS_BIT: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == ADDR_STATUS |=> reg_rdata == {1'b0, $past(ready_q), 6'h00})
      else $error("status read does not show chip ready");
   AST_CFG_BIT: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == ADDR_RESET |=> reg_rdata == {7'h00, $past(cfg_q)})
      else $error("reset register read wrong");
   AST_SCAN_BITS: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == ADDR_SCAN |=> reg_rdata == {6'h00, $past(scan_q)})
      else $error("scan rate read wrong");
   AST_GAIN_RSVD: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == ADDR_CHAN0_AMPLIFICATION |=> reg_rdata[7:6] == 2'h0)
      else $error("gain reserved bits not zero");
   AST_TWO_CH_READ: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_rd && cur == ADDR_EN && !FOUR_CHAN |=> reg_rdata[3:0] == 4'h0)
      else $error("two-channel enable bits not read as zero");

   // an accepted write shows on the field outputs one cycle later
   AST_EN_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
      ce && wr_ok && !full_rst && cur == ADDR_EN && FOUR_CHAN |=> chan_on == $past(reg_wdata[3:0]))
      else $error("channel enables not taken from the write");
   AST_LP_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
      ce && wr_ok && !full_rst && cur == ADDR_EN |=> lowpwr_on == $past(reg_wdata[7:4]))
      else $error("low-power enables not taken from the write");
   AST_SCAN_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
      ce && wr_ok && !full_rst && cur == ADDR_SCAN |=> normal_sample_rate_sel == $past(reg_wdata[1:0]))
      else $error("scan rate not taken from the write");
   AST_GAIN_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
      ce && wr_ok && !full_rst && cur == ADDR_CHAN0_AMPLIFICATION |=> chan0_amplification == $past(reg_wdata[5:0]))
      else $error("gain not taken from the write");
   AST_CFG_STOPS: assert property (@(posedge sys_clk) disable iff (reset)
      ce && wr_ok && !full_rst && cur == ADDR_RESET && reg_wdata[BIT_CFG] |=> !conv_run)
      else $error("config mode did not stop conversions");

   // the settle time after a full reset refuses writes and conversions
   AST_BOOT_REFUSE: assert property (@(posedge sys_clk) disable iff (reset)
      ce && reg_wr && !full_rst && !ready_q |=> $stable(en_q) && $stable(scan_q) && $stable(gain_q) && $stable(cfg_q))
      else $error("write accepted before chip ready");
   AST_BOOT_NO_CONV: assert property (@(posedge sys_clk) disable iff (reset)
      !ready_q |-> !rs.upd)
      else $error("conversion accepted before chip ready");
   AST_FULL_CLEARS: assert property (@(posedge sys_clk) disable iff (reset)
      ce && full_rst |=> rs.locked[0] == '0 && rs.locked[3] == '0)
      else $error("full reset left a result in place");
endmodule // itc_regs
`default_nettype wire

// ==== bench/itc_host_model.sv ====
// host model driving the register port of the bank
`timescale 1ns/100ps
`default_nettype none
module itc_host_model
(
   input wire logic sys_clk, // system clock
   input wire logic [7:0] reg_rdata, // read data from bank
   input wire logic reg_rvalid, // read data valid pulse
   output logic reg_addr_ld, // pointer load
   output logic [7:0] reg_addr, // pointer value
   output logic reg_wr, // write strobe
   output logic [7:0] reg_wdata, // write data
   output logic reg_rd // read strobe
);
   // idle values at time zero
   initial
   begin
      reg_addr_ld = 1'b0;
      reg_addr = 8'hA5;
      reg_wr = 1'b0;
      reg_wdata = 8'h5A;
      reg_rd = 1'b0;
   end

   // one write; callers wrap changes in config mode, save the gain write refused during the settle time, and keep reserved bits zero
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr_ld <= 1'b1;
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_addr_ld <= 1'b0;
      reg_wr <= 1'b0;
      // released lines flip so a stale value cannot pass for a held one
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
   endtask

   // one read; ld low continues a burst from the pointer
   task automatic rd(input logic ld, input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr_ld <= ld;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_addr_ld <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      // data only counts when the valid pulse came
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
   endtask
endmodule // itc_host_model
`default_nettype wire

// ==== bench/inductive_touch_cfg_data_regs_tb.sv ====
// self-checking testbench for the touch converter register bank
`timescale 1ns/100ps
`default_nettype none
module inductive_touch_cfg_data_regs_tb;
   import itc_pkg::*;
   logic sys_clk, reset, ce, reg_addr_ld, reg_wr, reg_rd, reg_rvalid; // port signals
   logic conv_valid, conv_run, chip_ready; // conversion side
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rdata_two, rd_q; // bytes
   logic [1:0] conv_chan, normal_sample_rate_sel; // channel, scan code
   logic [RES_W-1:0] conv_data; // conversion value
   logic [3:0] chan_on, lowpwr_on, chan_on_two; // enables
   logic [5:0] chan0_amplification; // gain
   logic [11:0] exp_res [4] = '{12'hABC, 12'h123, 12'h800, 12'h000}; // ch3 stays dropped
   int errors, checks_done; // tallies
   int n; // wait counter

   // 200 MHz clock
   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;

   itc_regs #(.FOUR_CHAN(1'b1)) dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .reg_addr_ld(reg_addr_ld),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data),
      .conv_run(conv_run), .chip_ready(chip_ready), .chan_on(chan_on), .lowpwr_on(lowpwr_on),
      .normal_sample_rate_sel(normal_sample_rate_sel), .chan0_amplification(chan0_amplification));
   // two-channel variant shares every input; only its enables are judged
   itc_regs #(.FOUR_CHAN(1'b0)) dut_two (.sys_clk(sys_clk), .reset(reset), .ce(ce), .reg_addr_ld(reg_addr_ld),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata_two),
      .reg_rvalid(), .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data), .conv_run(),
      .chip_ready(), .chan_on(chan_on_two), .lowpwr_on(), .normal_sample_rate_sel(), .chan0_amplification());
   itc_host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_addr_ld(reg_addr_ld), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

   // compare and count
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
      checks_done++;
      if (s !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   // read a register and compare it
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      host.rd(1'b1, a, rd_q);
      chk(nm, e, rd_q);
   endtask

   // one finished conversion pulse
   task automatic conv(input logic [1:0] ch, input logic [11:0] d);
      @(posedge sys_clk);
      conv_valid <= 1'b1;
      conv_chan <= ch;
      conv_data <= d;
      @(posedge sys_clk);
      conv_valid <= 1'b0;
      conv_data <= ~d;
   endtask

   // verdict and stop
   task automatic end_of_test;
      if (errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      repeat (10000) @(posedge sys_clk);
      errors++;
      end_of_test;
   end

   // main sequence
   initial
   begin
      reset = 1'b1;
      ce = 1'b1;
      conv_valid = 1'b0;
      conv_chan = 2'h0;
      conv_data = 12'h000;
      errors = 0;
      checks_done = 0;
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      // defaults after power-up
      rchk("status", ADDR_STATUS, 8'h40);
      rchk("reset_reg", ADDR_RESET, 8'h00);
      rchk("enables", ADDR_EN, 8'h1F);
      chk("enables_two", 12'h010, rdata_two);
      rchk("scan", ADDR_SCAN, 8'h01);
      rchk("gain", ADDR_CHAN0_AMPLIFICATION, 8'h28);
      rchk("unmapped", 8'h0B, 8'h00);
      for (int a = 2; a < 10; a++) rchk("result_rst", 8'(a), 8'h00);
      chk("chan_on", 12'hF, chan_on);
      chk("chan_on_two", 12'h3, chan_on_two);
      chk("lowpwr", 12'h1, lowpwr_on);
      // configuration mode holds conversions off
      host.wr(ADDR_RESET, 8'h01);
      chk("run_cfg", 12'h0, conv_run);
      for (int c = 0; c < 4; c++)
      begin
         host.wr(ADDR_SCAN, 8'(c));
         chk("scan_sel", 12'(c), normal_sample_rate_sel);
         rchk("scan_rd", ADDR_SCAN, 8'(c));
      end
      host.wr(ADDR_CHAN0_AMPLIFICATION, 8'h3F);
      chk("gain_port", 12'h3F, chan0_amplification);
      // clock enable low freezes the bank, so this write is lost
      @(posedge sys_clk) ce <= 1'b0;
      host.wr(ADDR_CHAN0_AMPLIFICATION, 8'h2A);
      @(posedge sys_clk) ce <= 1'b1;
      chk("gain_frozen", 12'h3F, chan0_amplification);
      host.wr(ADDR_EN, 8'h33);
      chk("lowpwr_33", 12'h3, lowpwr_on);
      chk("chan_on_33", 12'h3, chan_on);
      rchk("en_33", ADDR_EN, 8'h33);
      chk("enables_two_33", 12'h030, rdata_two);
      conv(2'h0, 12'h111);
      host.wr(ADDR_RESET, 8'h00);
      chk("run_back", 12'h1, conv_run);
      rchk("gain_kept", ADDR_CHAN0_AMPLIFICATION, 8'h3F);
      host.rd(1'b1, ADDR_STATUS, rd_q);
      rchk("cfg_drop", ADDR_RES_LO, 8'h00);
      // disabled channel drops its conversion
      conv(2'h3, 12'h555);
      host.wr(ADDR_RESET, 8'h01);
      host.wr(ADDR_EN, 8'h0F);
      host.wr(ADDR_RESET, 8'h00);
      for (int c = 0; c < 3; c++) conv(2'(c), exp_res[c]);
      host.rd(1'b1, ADDR_STATUS, rd_q);
      conv(2'h0, 12'h456);
      // burst through all result bytes from the locked copy
      for (int i = 0; i < 8; i++)
      begin
         host.rd(i == 0, ADDR_RES_LO, rd_q);
         chk("result", (i % 2) ? {8'h00, exp_res[i / 2][11:8]} : {4'h0, exp_res[i / 2][7:0]}, rd_q);
      end
      host.rd(1'b1, ADDR_STATUS, rd_q);
      rchk("relock_lo", ADDR_RES_LO, 8'h56);
      rchk("relock_hi", 8'h03, 8'h04);
      rchk("ch1_hi", 8'h05, 8'h01);
      // full reset and settle
      host.wr(ADDR_RESET, 8'h10);
      chk("ready_low", 12'h0, chip_ready);
      chk("run_low", 12'h0, conv_run);
      rchk("status_busy", ADDR_STATUS, 8'h00);
      host.wr(ADDR_CHAN0_AMPLIFICATION, 8'h15);
      for (n = 0; n < 40 && chip_ready !== 1'b1; n++) @(posedge sys_clk);
      #1;
      chk("ready_back", 12'h1, chip_ready);
      chk("run_ready", 12'h1, conv_run);
      rchk("status_ok", ADDR_STATUS, 8'h40);
      rchk("gain_def", ADDR_CHAN0_AMPLIFICATION, 8'h28);
      rchk("en_def", ADDR_EN, 8'h1F);
      rchk("scan_def", ADDR_SCAN, 8'h01);
      rchk("res_clr", ADDR_RES_LO, 8'h00);
      end_of_test;
   end
endmodule // inductive_touch_cfg_data_regs_tb
`default_nettype wire
